// ### logic/upc_regs.sv
// User control and power control register bank with its derived control outputs
//
// Function
// - Run bit lets motion processor operate; clearing freezes it after current sample.
// - Enabled processor keeps running with all sensors off, except at 8 kHz rate.
// - Queue mode bit gates serial access to FIFO only, not internal writes.
// - Motion processor reset bit pulses reset; bit clears after one cycle.
// - Queue reset bit pulses FIFO reset; bit clears after one cycle.
// - Path reset pulses all sensor paths and data clear for one 8 MHz cycle.
// - Whole chip restore returns registers to defaults, then clears itself.
// - Sleep bit sets sleep mode and resets to 1.
// - Duty cycling without sleep or standby alternates sleep and one accel sample; while cycling, O_SLEEP only asserts with gyro off and power two bit 7 clear.
// - Duty cycling with all accel axes off wakes but takes no samples.
// - Gyro standby keeps drive and PLL but disables sense paths.
// - Thermal sensor off bit disables the temperature sensor.
// - Three-bit clock source field; code 0 is the internal 20 MHz oscillator.
// - With power two bit 7 clear, sleep when gyro off and accel duty cycling.
// - Motion processor lowpower block clear allows running in low-power accel mode.
// - Bits 5,4,3 switch off accel X, Y, Z axes when set.
// - Bits 2,1,0 switch off gyro X, Y, Z axes when set.
`include "upc_consts.svh"
`default_nettype none
module upc_regs #(
  parameter int RESTORE_CYC = `UPC_RESTORE_CYC,
  parameter int PATH_PULSE_CYC = `UPC_PATH_PULSE_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_PROC_SAMPLE_DONE,
  input wire logic I_RATE_8KHZ,
  input wire logic I_SAMPLE_TICK,
  output logic [7:0] O_RDATA,
  output logic O_PROC_RUN,
  output logic O_PROC_RESET,
  output logic O_QUEUE_SERIAL_EN,
  output logic O_QUEUE_RESET,
  output logic O_SLAVE_RESET,
  output logic O_PATH_RESET,
  output logic O_RESTORE_BUSY,
  output logic O_SLEEP,
  output logic O_ACCEL_SAMPLE,
  output logic O_GYRO_SENSE_EN,
  output logic O_TEMP_EN,
  output logic [2:0] O_CLK_SEL,
  output logic O_PROC_LOWPOWER_OK,
  output logic [2:0] O_ACCEL_AXIS_EN,
  output logic [2:0] O_GYRO_AXIS_EN
);
  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] user_reg;
  logic [7:0] user_next;
  logic [7:0] pwr1_reg;
  logic [7:0] pwr1_next;
  logic [7:0] pwr2_reg;
  logic [7:0] pwr2_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic proc_rst_reg;
  logic proc_rst_next;
  logic queue_rst_reg;
  logic queue_rst_next;
  logic slave_rst_reg;
  logic slave_rst_next;
  logic path_req_reg;
  logic path_req_next;
  logic [7:0] restore_cnt_reg;
  logic [7:0] restore_cnt_next;
  upc_pkg::upc_proc_e proc_reg;
  upc_pkg::upc_proc_e proc_next;
  logic path_pulse;
  logic wr_user;
  logic wr_p1;
  logic wr_p2;
  logic restoring;

  assign wr_user = I_WR_EN && (I_ADDR == `UPC_OFS_USER_CONTROL);
  assign wr_p1 = I_WR_EN && (I_ADDR == `UPC_OFS_POWER_ONE);
  assign wr_p2 = I_WR_EN && (I_ADDR == `UPC_OFS_POWER_TWO);
  assign restoring = (restore_cnt_reg != 8'h00);

  // ****************************************
  // Register writes, self-clearing strobes and restore
  // ****************************************
  always_comb
  begin
    user_next = user_reg;
    pwr1_next = pwr1_reg;
    pwr2_next = pwr2_reg;
    proc_rst_next = 1'b0;
    queue_rst_next = 1'b0;
    slave_rst_next = 1'b0;
    path_req_next = 1'b0;
    restore_cnt_next = restoring ? restore_cnt_reg - 8'h01 : 8'h00;
    if (restoring)
    begin
      // Hold every register at its default while the restore runs
      user_next = `UPC_RST_USER_CONTROL;
      pwr1_next = `UPC_RST_POWER_ONE;
      pwr2_next = `UPC_RST_POWER_TWO;
    end
    else
    begin
      if (wr_user)
      begin
        user_next = I_WDATA & `UPC_UC_WMASK;
        slave_rst_next = I_WDATA[`UPC_UC_SLAVE_RST_BIT];
        proc_rst_next = I_WDATA[`UPC_UC_PROC_RST_BIT];
        queue_rst_next = I_WDATA[`UPC_UC_QUEUE_RST_BIT];
        path_req_next = I_WDATA[`UPC_UC_PATH_RST_BIT];
      end
      if (wr_p1)
      begin
        pwr1_next = I_WDATA & `UPC_P1_WMASK;
        if (I_WDATA[`UPC_P1_RESTORE_BIT])
          restore_cnt_next = 8'(RESTORE_CYC);
      end
      if (wr_p2)
        pwr2_next = I_WDATA;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SRST)
    begin
      user_reg <= `UPC_RST_USER_CONTROL;
      pwr1_reg <= `UPC_RST_POWER_ONE;
      pwr2_reg <= `UPC_RST_POWER_TWO;
      proc_rst_reg <= 1'b0;
      queue_rst_reg <= 1'b0;
      slave_rst_reg <= 1'b0;
      path_req_reg <= 1'b0;
      restore_cnt_reg <= 8'h00;
    end
    else
    begin
      user_reg <= user_next;
      pwr1_reg <= pwr1_next;
      pwr2_reg <= pwr2_next;
      proc_rst_reg <= proc_rst_next;
      queue_rst_reg <= queue_rst_next;
      slave_rst_reg <= slave_rst_next;
      path_req_reg <= path_req_next;
      restore_cnt_reg <= restore_cnt_next;
    end
  end

  // Path reset stretched to one 8 MHz period
  upc_pulse #(
    .LEN(PATH_PULSE_CYC)
  ) u_path_pulse (
    .i_clk(I_MCLK),
    .i_rst(I_SRST),
    .i_start(path_req_reg),
    .o_pulse(path_pulse)
  );

  // ****************************************
  // Motion processor run state
  // ****************************************
  always_comb
  begin
    proc_next = proc_reg;
    unique case (proc_reg)
      upc_pkg::UPC_RUN:
        if (!user_reg[`UPC_UC_RUN_BIT])
          proc_next = I_PROC_SAMPLE_DONE ? upc_pkg::UPC_FROZEN : upc_pkg::UPC_DRAIN;
      upc_pkg::UPC_DRAIN:
        if (user_reg[`UPC_UC_RUN_BIT])
          proc_next = upc_pkg::UPC_RUN;
        else if (I_PROC_SAMPLE_DONE)
          proc_next = upc_pkg::UPC_FROZEN;
      upc_pkg::UPC_FROZEN:
        if (user_reg[`UPC_UC_RUN_BIT])
          proc_next = upc_pkg::UPC_RUN;
      default:
        proc_next = upc_pkg::UPC_FROZEN;
    endcase
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SRST)
      proc_reg <= upc_pkg::UPC_FROZEN;
    else
      proc_reg <= proc_next;
  end

  // ****************************************
  // Derived controls and read data
  // ****************************************
  logic all_accel_off;
  logic all_gyro_off;
  logic cycling;
  logic sleep_c;
  logic proc_run_c;
  logic accel_sample_c;

  assign all_accel_off = &pwr2_reg[5:3];
  assign all_gyro_off = &pwr2_reg[2:0];
  assign cycling = pwr1_reg[`UPC_P1_CYCLE_BIT] && !pwr1_reg[`UPC_P1_SLEEP_BIT]
                   && !pwr1_reg[`UPC_P1_STANDBY_BIT];
  // Sleep bit, or low-power sleep when gyro off while duty cycling
  assign sleep_c = pwr1_reg[`UPC_P1_SLEEP_BIT]
                   || (!pwr2_reg[7] && all_gyro_off && cycling && !I_SAMPLE_TICK);
  // Runs with sensors off, except at the 8 kHz rate when all are off
  assign proc_run_c = (proc_reg != upc_pkg::UPC_FROZEN)
                      && !(I_RATE_8KHZ && all_accel_off && all_gyro_off)
                      && !(cycling && pwr2_reg[6]);
  // One sample per tick; wakes but takes none if all accel axes are off
  assign accel_sample_c = cycling && I_SAMPLE_TICK && !all_accel_off;

  always_comb
  begin
    rdata_next = rdata_reg;
    if (I_RD_EN)
    begin
      unique case (I_ADDR)
        `UPC_OFS_USER_CONTROL: rdata_next = user_reg;
        `UPC_OFS_POWER_ONE: rdata_next = pwr1_reg;
        `UPC_OFS_POWER_TWO: rdata_next = pwr2_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SRST)
    begin
      rdata_reg <= 8'h00;
      O_PROC_RUN <= 1'b0;
      O_PROC_RESET <= 1'b0;
      O_QUEUE_SERIAL_EN <= 1'b0;
      O_QUEUE_RESET <= 1'b0;
      O_SLAVE_RESET <= 1'b0;
      O_PATH_RESET <= 1'b0;
      O_RESTORE_BUSY <= 1'b0;
      O_SLEEP <= 1'b1;
      O_ACCEL_SAMPLE <= 1'b0;
      O_GYRO_SENSE_EN <= 1'b1;
      O_TEMP_EN <= 1'b1;
      O_CLK_SEL <= `UPC_CLK_INTERNAL;
      O_PROC_LOWPOWER_OK <= 1'b1;
      O_ACCEL_AXIS_EN <= 3'h7;
      O_GYRO_AXIS_EN <= 3'h7;
    end
    else
    begin
      rdata_reg <= rdata_next;
      O_PROC_RUN <= proc_run_c;
      O_PROC_RESET <= proc_rst_reg;
      O_QUEUE_SERIAL_EN <= user_reg[`UPC_UC_QUEUE_BIT];
      O_QUEUE_RESET <= queue_rst_reg;
      O_SLAVE_RESET <= slave_rst_reg;
      O_PATH_RESET <= path_pulse;
      O_RESTORE_BUSY <= restoring;
      O_SLEEP <= sleep_c;
      O_ACCEL_SAMPLE <= accel_sample_c;
      O_GYRO_SENSE_EN <= !pwr1_reg[`UPC_P1_STANDBY_BIT] && !sleep_c;
      O_TEMP_EN <= !pwr1_reg[`UPC_P1_TEMP_OFF_BIT];
      O_CLK_SEL <= pwr1_reg[2:0];
      O_PROC_LOWPOWER_OK <= !pwr2_reg[6];
      O_ACCEL_AXIS_EN <= ~pwr2_reg[5:3];
      O_GYRO_AXIS_EN <= ~pwr2_reg[2:0];
    end
  end

  assign O_RDATA = rdata_reg;

  // ****************************************
  // Checks
  // ****************************************
  AST_PROC_RST_ONE: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (wr_user && I_WDATA[3] && !restoring) |=> ##1 O_PROC_RESET ##1 !O_PROC_RESET)
    else $error("processor reset pulse not one cycle");
  AST_QUEUE_RST_ONE: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (wr_user && I_WDATA[2] && !restoring) |=> ##1 O_QUEUE_RESET ##1 !O_QUEUE_RESET)
    else $error("queue reset pulse not one cycle");
  AST_SELF_CLEAR_READ: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (I_RD_EN && I_ADDR == `UPC_OFS_USER_CONTROL) |=> (O_RDATA[5:0] == 6'h00))
    else $error("self-clearing or reserved bits read nonzero");
  AST_PATH_PULSE: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    $rose(path_pulse) |-> path_pulse[*7] ##1 !path_pulse)
    else $error("path reset pulse length wrong");
  AST_RESTORE_DEF: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    $fell(restoring) |-> (pwr1_reg == `UPC_RST_POWER_ONE && user_reg == 8'h00))
    else $error("restore did not load defaults");
  AST_RESTORE_ENDS: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (wr_p1 && I_WDATA[7] && !restoring) |=> restoring ##[1:20] !restoring)
    else $error("restore did not finish");
  AST_FREEZE: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (proc_reg == upc_pkg::UPC_DRAIN && !user_reg[7] && !I_PROC_SAMPLE_DONE) |=> proc_reg != upc_pkg::UPC_FROZEN)
    else $error("processor froze before sample finished");
  AST_AXIS: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    ##1 (O_ACCEL_AXIS_EN == ~$past(pwr2_reg[5:3])))
    else $error("accel axis enables wrong");
  AST_NO_SAMPLE: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    all_accel_off |=> !O_ACCEL_SAMPLE)
    else $error("sample taken with all accel axes off");
endmodule
`default_nettype wire

// ### logic/upc_consts.svh
// Offsets, field positions, reset values and timing counts of the user and power control registers
`ifndef UPC_CONSTS_SVH
`define UPC_CONSTS_SVH

`define UPC_OFS_USER_CONTROL 8'h6a
`define UPC_OFS_POWER_ONE 8'h6b
`define UPC_OFS_POWER_TWO 8'h6c

`define UPC_UC_RUN_BIT 7
`define UPC_UC_QUEUE_BIT 6
`define UPC_UC_SLAVE_RST_BIT 4
`define UPC_UC_PROC_RST_BIT 3
`define UPC_UC_QUEUE_RST_BIT 2
`define UPC_UC_PATH_RST_BIT 0
`define UPC_UC_WMASK 8'hc0

`define UPC_P1_RESTORE_BIT 7
`define UPC_P1_SLEEP_BIT 6
`define UPC_P1_CYCLE_BIT 5
`define UPC_P1_STANDBY_BIT 4
`define UPC_P1_TEMP_OFF_BIT 3
`define UPC_P1_WMASK 8'h7f

`define UPC_RST_USER_CONTROL 8'h00
`define UPC_RST_POWER_ONE 8'h40
`define UPC_RST_POWER_TWO 8'h00

`define UPC_CLK_INTERNAL 3'h0
`define UPC_FAST_RATE_KHZ 16'h1f40

`define UPC_MCLK_HZ 50000000
`define UPC_PULSE_CLK_HZ 8000000
`define UPC_PATH_PULSE_CYC ((`UPC_MCLK_HZ + `UPC_PULSE_CLK_HZ - 1) / `UPC_PULSE_CLK_HZ)
`define UPC_RESTORE_CYC 16

`endif

// ### logic/upc_pkg.sv
// Types shared by the user and power control register block
`default_nettype none
package upc_pkg;
  typedef enum logic [1:0] {UPC_RUN, UPC_DRAIN, UPC_FROZEN} upc_proc_e;
  typedef logic [7:0] upc_byte_t;
endpackage
`default_nettype wire

// ### logic/upc_pulse.sv
// Stretches a one-cycle request into a fixed-length reset pulse
`default_nettype none
module upc_pulse #(
  parameter int LEN = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_pulse
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  // Load on request, count down to zero
  always_comb
  begin
    cnt_next = cnt_reg;
    if (i_start)
      cnt_next = 8'(LEN);
    else if (cnt_reg != 8'h00)
      cnt_next = cnt_reg - 8'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_next;
  end

  assign o_pulse = (cnt_reg != 8'h00);
endmodule
`default_nettype wire

// ### tb/upc_host.sv
// Host model that drives the register write and read strobes
`default_nettype none
module upc_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle strobes from time zero
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // One-cycle write strobe; address is scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // One-cycle read strobe; data is registered and held, so taken an edge on
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b0;
    o_addr = ~a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the user and power control register block
`include "upc_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals
  // ****************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic done = 1'b0;
  logic r8k = 1'b0;
  logic tick = 1'b0;
  logic wr_en, rd_en, run, prr, qen, qrr, srr, par, busy, slp, asm, gen, ten, lpok;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] csel, aen, gaxe;
  int mismatches = 0;
  int compares = 0;
  int n_pr = 0;
  int n_qr = 0;
  int n_sr = 0;
  int n_pa = 0;
  int n_as = 0;
  int i;
  // Clock at 50 MHz
  always #10 clk = ~clk;
  upc_host upc_host_i (.i_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
    .o_wdata(wdata));
  upc_regs upc_regs_i (.I_MCLK(clk), .I_SRST(srst), .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr),
    .I_WDATA(wdata), .I_PROC_SAMPLE_DONE(done), .I_RATE_8KHZ(r8k), .I_SAMPLE_TICK(tick), .O_RDATA(rdata),
    .O_PROC_RUN(run), .O_PROC_RESET(prr), .O_QUEUE_SERIAL_EN(qen), .O_QUEUE_RESET(qrr), .O_SLAVE_RESET(srr),
    .O_PATH_RESET(par), .O_RESTORE_BUSY(busy), .O_SLEEP(slp), .O_ACCEL_SAMPLE(asm), .O_GYRO_SENSE_EN(gen),
    .O_TEMP_EN(ten), .O_CLK_SEL(csel), .O_PROC_LOWPOWER_OK(lpok), .O_ACCEL_AXIS_EN(aen),
    .O_GYRO_AXIS_EN(gaxe));
  // Counts cycles that each pulse output stands high
  always @(posedge clk)
  begin
    if (prr === 1'b1) n_pr++;
    if (qrr === 1'b1) n_qr++;
    if (srr === 1'b1) n_sr++;
    if (par === 1'b1) n_pa++;
    if (asm === 1'b1) n_as++;
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    upc_host_i.rd(a, d);
    chk("rdata", e, d);
  endtask
  task automatic conclude();
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    step(5);
    srst = 1'b0;
    r(8'h6a, 8'h00);
    r(8'h6b, 8'h40);
    r(8'h6c, 8'h00);
    r(8'h10, 8'h00);
    chk("sleep", 8'h01, {7'h0, slp});
    chk("clk_sel", 8'h00, {5'h0, csel});
    // All strobes at once, reserved bits set too
    upc_host_i.wr(8'h6a, 8'hff);
    step(20);
    chk("proc_rst", 8'h01, n_pr[7:0]);
    chk("queue_rst", 8'h01, n_qr[7:0]);
    chk("slave_rst", 8'h01, n_sr[7:0]);
    chk("path_rst", 8'(`UPC_PATH_PULSE_CYC), n_pa[7:0]);
    chk("run", 8'h01, {7'h0, run});
    chk("queue_en", 8'h01, {7'h0, qen});
    r(8'h6a, 8'hc0);
    // Run cleared: processor drains the current sample first
    upc_host_i.wr(8'h6a, 8'h40);
    step(4);
    chk("run", 8'h01, {7'h0, run});
    done = 1'b1;
    step(1);
    done = 1'b0;
    step(4);
    chk("run", 8'h00, {7'h0, run});
    // All sensors off, processor blocked only at the fast rate
    upc_host_i.wr(8'h6c, 8'h3f);
    upc_host_i.wr(8'h6a, 8'h80);
    r8k = 1'b1;
    step(4);
    chk("run", 8'h00, {7'h0, run});
    chk("queue_en", 8'h00, {7'h0, qen});
    r8k = 1'b0;
    step(4);
    chk("run", 8'h01, {7'h0, run});
    upc_host_i.wr(8'h6c, 8'hd4);
    step(3);
    chk("accel_en", 8'h05, {5'h0, aen});
    chk("gyro_en", 8'h03, {5'h0, gaxe});
    chk("lp_ok", 8'h00, {7'h0, lpok});
    r(8'h6c, 8'hd4);
    upc_host_i.wr(8'h6b, 8'h18);
    step(3);
    chk("sleep", 8'h00, {7'h0, slp});
    chk("sense_en", 8'h00, {7'h0, gen});
    chk("temp_en", 8'h00, {7'h0, ten});
    // Duty cycling: one sample per tick, none with accel axes off
    upc_host_i.wr(8'h6c, 8'h80);
    upc_host_i.wr(8'h6b, 8'h20);
    step(3);
    tick = 1'b1;
    step(1);
    tick = 1'b0;
    step(4);
    chk("samples", 8'h01, n_as[7:0]);
    upc_host_i.wr(8'h6c, 8'hb8);
    step(3);
    tick = 1'b1;
    step(1);
    tick = 1'b0;
    step(4);
    chk("samples", 8'h01, n_as[7:0]);
    upc_host_i.wr(8'h6c, 8'h07);
    step(3);
    chk("sleep", 8'h01, {7'h0, slp});
    // Whole restore; a write meanwhile is dropped
    upc_host_i.wr(8'h6b, 8'h80);
    upc_host_i.wr(8'h6c, 8'hff);
    for (i = 0; i < 60 && busy !== 1'b0; i++) step(1);
    // A restore that never ends counts against the run and skips the readback
    if (i == 60)
    begin
      mismatches++;
      $display("FAIL restore_busy expected 0 seen 1");
    end
    else
    begin
      r(8'h6a, 8'h00);
      r(8'h6b, 8'h40);
      r(8'h6c, 8'h00);
      chk("sleep", 8'h01, {7'h0, slp});
      chk("temp_en", 8'h01, {7'h0, ten});
    end
    conclude();
  end
endmodule
`default_nettype wire
